// ---- logic/host_normal_event_status.sv ----
`timescale 1ns/1ps
`include "host_evt_map.svh"

// Summary of operation
// - read buffer ready on available rise
// - tuning commands each set read ready while the tuning control is on
// - write buffer ready on available rise
// - dma event at page boundary hit
// - descriptor interrupt attribute sets dma event
// - no dma event after transfer complete
// - gap event only when halt requested
// - read gap event on line busy fall
// - read wait offered for read halting
// - write gap event on write active fall
// - complete on transfer end or busy command
// - read complete on read active fall
// - complete flag voids timeout meaning
module host_normal_event_status
    import host_evt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // buffer state
    input wire logic buf_rd_en,
    input wire logic buf_wr_en,
    // transfer state
    input wire logic data_line_busy,
    input wire logic read_active,
    input wire logic write_active,
    input wire logic busy_cmd_done,
    input wire logic tuning_cmd_done,
    // dma engine
    input wire logic dma_mode,
    input wire logic dma_page_hit,
    input wire logic desc_int_hit,
    // outputs to the card side and system
    output logic read_wait_req,
    output logic timeout_meaningful,
    output logic irq
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    evt_t status; // sticky event flags
    evt_t mask; // interrupt enables
    logic [1:0] ctrl; // halt and tuning controls
    logic xfer_done; // current transfer has completed
    logic read_dir; // last transfer was a read
    evt_t next_status; // status after this cycle
    evt_t next_mask; // mask after this cycle

    // ----------------------------------------
    // edge detection of transfer levels
    // ----------------------------------------
    logic [4:0] lvl; // watched levels
    logic [4:0] rise; // rising pulses
    logic [4:0] fall; // falling pulses

    assign lvl = {write_active, read_active, data_line_busy, buf_wr_en, buf_rd_en};

    evt_edge_detect #(
        .W(5)
    ) u_edges (
        .clk(clk),
        .rst_n(rst_n),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    // named edges
    wire rd_en_rise = rise[0];
    wire wr_en_rise = rise[1];
    wire busy_fall = fall[2];
    wire rd_act_rise = rise[3];
    wire rd_act_fall = fall[3];
    wire wr_act_rise = rise[4];
    wire wr_act_fall = fall[4];

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    wire hit_status = (addr == `EVT_STATUS_OFS);
    wire hit_mask = (addr == `EVT_MASK_OFS);
    wire hit_ctrl = (addr == `EVT_CTRL_OFS);
    wire hit_state = (addr == `EVT_STATE_OFS);
    wire wr_status = wr & hit_status;
    wire wr_mask = wr & hit_mask;
    wire wr_ctrl = wr & hit_ctrl;

    // control fields
    wire halt_at_gap_req = ctrl[`CTRL_HALT_BIT];
    wire tuning_run = ctrl[`CTRL_TUNE_BIT];

    // ----------------------------------------
    // event conditions
    // ----------------------------------------
    // read buffer became available, or one tuning block ran
    wire set_rd_ready = rd_en_rise | (tuning_run & tuning_cmd_done);
    // write buffer became available
    wire set_wr_ready = wr_en_rise;
    // read ends at a gap when the data lines go idle
    wire gap_read = halt_at_gap_req & read_dir & busy_fall;
    // write ends at a gap after crc status closes write active
    wire gap_write = halt_at_gap_req & wr_act_fall;
    wire set_gap = gap_read | gap_write;
    // completion of read, write or busy command
    wire set_done = rd_act_fall | wr_act_fall | busy_cmd_done;
    // a new transfer reopens the dma window
    wire xfer_start = rd_act_rise | wr_act_rise;
    // raw dma causes per engine flavour
    wire dma_simple = (dma_mode == DMA_SIMPLE) & dma_page_hit;
    wire dma_desc = (dma_mode == DMA_DESC) & desc_int_hit;
    // dma events are dropped once the transfer has completed
    wire dma_blocked = (xfer_done & ~xfer_start) | set_done;
    wire set_dma = (dma_simple | dma_desc) & ~dma_blocked;

    // all set requests in status layout
    evt_t evt_set;
    assign evt_set = {set_rd_ready, set_wr_ready, set_dma, set_gap, set_done};

    // write one to clear, write zero leaves a flag alone
    evt_t evt_clr;
    assign evt_clr = wr_status ? wdata[5:1] : `EVT_STATUS_RST;

    // set wins over a clear in the same cycle
    assign next_status = (status & ~evt_clr) | evt_set;
    assign next_mask = wr_mask ? wdata[5:1] : mask;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    word_t rd_word;
    assign rd_word = hit_status ? {26'h0, status, 1'b0} :
                     hit_mask ? {26'h0, mask, 1'b0} :
                     hit_ctrl ? {30'h0, ctrl} :
                     hit_state ? {25'h0, lvl, read_dir, xfer_done} :
                     32'h0;

    // ----------------------------------------
    // status and mask registers
    // ----------------------------------------
    // sticky flags hold until software clears them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= `EVT_STATUS_RST;
        end else begin
            status <= next_status;
        end
    end

    // interrupt mask
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= `EVT_MASK_RST;
        end else begin
            mask <= next_mask;
        end
    end

    // control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `EVT_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= wdata[1:0];
        end
    end

    // ----------------------------------------
    // transfer tracking
    // ----------------------------------------
    // completion latch, reopened by the next transfer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_done <= 1'b0;
        end else if (set_done) begin
            xfer_done <= 1'b1;
        end else if (xfer_start) begin
            xfer_done <= 1'b0;
        end
    end

    // direction of the latest transfer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            read_dir <= 1'b0;
        end else if (rd_act_rise) begin
            read_dir <= 1'b1;
        end else if (wr_act_rise) begin
            read_dir <= 1'b0;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0;
        end else begin
            rdata <= rd ? rd_word : 32'h0;
        end
    end

    // read wait asked while a halted read may need to pause the card
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            read_wait_req <= 1'b0;
        end else begin
            read_wait_req <= halt_at_gap_req & read_active;
        end
    end

    // timeout status is only meaningful while completion is clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_meaningful <= 1'b1;
        end else begin
            timeout_meaningful <= ~next_status[`EVT_DONE_BIT];
        end
    end

    // level interrupt from unmasked flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & next_mask);
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_rd_ready_rise: assert property (
        $rose(buf_rd_en) |=> status[`EVT_RD_READY_BIT])
        else $error("read ready not set on buffer rise");

    a_tune_sets_ready: assert property (
        tuning_run && tuning_cmd_done |=> status[`EVT_RD_READY_BIT])
        else $error("tuning command did not set read ready");

    a_wr_ready_rise: assert property (
        $rose(buf_wr_en) |=> status[`EVT_WR_READY_BIT])
        else $error("write ready not set on buffer rise");

    a_dma_page_hit: assert property (
        dma_mode == DMA_SIMPLE && dma_page_hit && !xfer_done && !set_done
        |=> status[`EVT_DMA_BIT])
        else $error("page boundary did not set dma event");

    a_dma_desc_hit: assert property (
        dma_mode == DMA_DESC && desc_int_hit && !xfer_done && !set_done
        |=> status[`EVT_DMA_BIT])
        else $error("descriptor attribute did not set dma event");

    a_dma_after_done: assert property (
        xfer_done && !xfer_start && !status[`EVT_DMA_BIT] |=> !status[`EVT_DMA_BIT])
        else $error("dma event after transfer complete");

    a_gap_needs_halt: assert property (
        !halt_at_gap_req && !status[`EVT_GAP_BIT] |=> !status[`EVT_GAP_BIT])
        else $error("gap event without halt request");

    a_gap_read_fall: assert property (
        halt_at_gap_req && read_dir && $fell(data_line_busy) |=> status[`EVT_GAP_BIT])
        else $error("read gap event missing");

    a_gap_write_fall: assert property (
        halt_at_gap_req && $fell(write_active) |=> status[`EVT_GAP_BIT])
        else $error("write gap event missing");

    a_read_wait_follows: assert property (
        halt_at_gap_req && read_active |=> read_wait_req)
        else $error("read wait not requested");

    a_done_read_fall: assert property (
        $fell(read_active) |=> status[`EVT_DONE_BIT] ##0 !timeout_meaningful)
        else $error("read completion not flagged");

    a_done_busy_cmd: assert property (
        busy_cmd_done |=> status[`EVT_DONE_BIT])
        else $error("busy command completion not flagged");

    a_flag_sticky: assert property (
        status[`EVT_DONE_BIT] && !(wr_status && wdata[`EVT_DONE_BIT])
        |=> status[`EVT_DONE_BIT])
        else $error("completion flag lost without clear");

    a_irq_tracks: assert property (
        ##1 irq == |(status & mask))
        else $error("interrupt does not follow masked status");

    a_rdata_window: assert property (
        !$past(rd) |-> rdata == 32'h0)
        else $error("read data outside its cycle");

    c_tuning: cover property (tuning_run && tuning_cmd_done ##1 status[5]);
    c_gap_write: cover property (halt_at_gap_req && $fell(write_active));
    c_dma_desc: cover property (dma_desc && !dma_blocked ##1 irq);
    c_clear_race: cover property (wr_status && wdata[1] && set_done ##1 status[1]);

endmodule : host_normal_event_status

// ---- pkg/host_evt_map.svh ----
`ifndef HOST_EVT_MAP_SVH
`define HOST_EVT_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define EVT_STATUS_OFS 8'h00
`define EVT_MASK_OFS 8'h04
`define EVT_CTRL_OFS 8'h08
`define EVT_STATE_OFS 8'h0c

// ----------------------------------------
// event bit positions in status and mask
// ----------------------------------------
`define EVT_RD_READY_BIT 5
`define EVT_WR_READY_BIT 4
`define EVT_DMA_BIT 3
`define EVT_GAP_BIT 2
`define EVT_DONE_BIT 1

// ----------------------------------------
// control bit positions
// ----------------------------------------
`define CTRL_HALT_BIT 0
`define CTRL_TUNE_BIT 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define EVT_STATUS_RST 5'h00
`define EVT_MASK_RST 5'h00
`define EVT_CTRL_RST 2'h0

`endif

// ---- pkg/host_evt_pkg.sv ----
// ----------------------------------------
// shared types of the event status block
// ----------------------------------------
package host_evt_pkg;

    // register bus address and data
    typedef logic [7:0] addr_t;
    typedef logic [31:0] word_t;

    // sticky event bits, indexed 5 down to 1
    typedef logic [5:1] evt_t;

    // dma engine flavour
    typedef enum logic {
        DMA_SIMPLE = 1'b0,
        DMA_DESC = 1'b1
    } dma_mode_t;

endpackage : host_evt_pkg

// ---- logic/evt_edge_detect.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// bank of rise and fall detectors
// ----------------------------------------
module evt_edge_detect #(
    parameter int W = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels to watch
    input wire logic [W-1:0] level,
    // one-cycle edge pulses
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    // previous sample of each level
    logic [W-1:0] prev;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // remember last cycle's level
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    prev[i] <= 1'b0;
                end else begin
                    prev[i] <= level[i];
                end
            end
            // edges compare now against last cycle
            assign rise[i] = level[i] & ~prev[i];
            assign fall[i] = ~level[i] & prev[i];
        end
    endgenerate

endmodule : evt_edge_detect

// ---- tb/card_bus_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// far side: card transfer sequencer
// ----------------------------------------
module card_bus_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // transfer requests from the bench
    input wire logic go_read,
    input wire logic go_write,
    // read-wait request seen from the host
    input wire logic read_wait_req,
    // transfer state levels toward the host
    output logic buf_rd_en,
    output logic buf_wr_en,
    output logic data_line_busy,
    output logic read_active,
    output logic write_active,
    output logic idle,
    // read wait was seen during the latest transfer
    output logic wait_seen
);
    logic [2:0] step; // position in the transfer, 0 when idle
    logic dir_read; // current transfer reads from the card
    logic held; // read wait was requested during this transfer

    // step counter runs 1 to 7 then back to idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step <= 3'h0;
            dir_read <= 1'b0;
            held <= 1'b0;
        end else if (step == 3'h0 && (go_read || go_write)) begin
            // start a new transfer
            step <= 3'h1;
            dir_read <= go_read;
            held <= 1'b0;
        end else if (step != 3'h0) begin
            // advance, note read wait while holding the line
            step <= step + 3'h1;
            held <= held | read_wait_req;
        end
    end

    // line busy ends before the direction flag drops
    assign data_line_busy = (step >= 3'h1) && (step <= 3'h5);
    assign read_active = dir_read && (step >= 3'h1) && (step <= 3'h6);
    assign write_active = !dir_read && (step >= 3'h1) && (step <= 3'h6);
    // buffer ready pulses inside the transfer
    assign buf_rd_en = dir_read && (step == 3'h3);
    assign buf_wr_en = !dir_read && (step == 3'h1);
    assign idle = (step == 3'h0);
    assign wait_seen = held;
endmodule : card_bus_model

// ---- tb/tb_host_normal_event_status.sv ----
`timescale 1ns/1ps
`include "host_evt_map.svh"

// ----------------------------------------
// bench for the normal event status block
// ----------------------------------------
module tb_host_normal_event_status;
    import host_evt_pkg::*;
    logic clk, rst_n, wr, rd, go_read, go_write, idle;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic buf_rd_en, buf_wr_en, data_line_busy, read_active, write_active;
    logic busy_cmd_done, tuning_cmd_done, dma_mode, dma_page_hit, desc_int_hit;
    logic read_wait_req, timeout_meaningful, irq, wait_seen;
    int fails = 0;
    int num_checks = 0;

    host_normal_event_status dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .buf_rd_en(buf_rd_en), .buf_wr_en(buf_wr_en),
        .data_line_busy(data_line_busy), .read_active(read_active),
        .write_active(write_active), .busy_cmd_done(busy_cmd_done),
        .tuning_cmd_done(tuning_cmd_done), .dma_mode(dma_mode), .dma_page_hit(dma_page_hit),
        .desc_int_hit(desc_int_hit), .read_wait_req(read_wait_req),
        .timeout_meaningful(timeout_meaningful), .irq(irq));

    card_bus_model card (.clk(clk), .rst_n(rst_n), .go_read(go_read), .go_write(go_write),
        .read_wait_req(read_wait_req), .buf_rd_en(buf_rd_en), .buf_wr_en(buf_wr_en),
        .data_line_busy(data_line_busy), .read_active(read_active),
        .write_active(write_active), .idle(idle), .wait_seen(wait_seen));

    // ----------------------------------------
    // clock
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // one-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stands in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : rd_chk

    // start a card transfer, return once the sequencer is running
    task automatic start_xfer(input logic is_read);
        @(posedge clk);
        go_read <= is_read;
        go_write <= !is_read;
        @(posedge clk);
        go_read <= 1'b0;
        go_write <= 1'b0;
    endtask : start_xfer

    // bounded wait for the sequencer to fall idle, then let events land
    task automatic wait_idle();
        int n;
        n = 0;
        @(posedge clk);
        while (idle !== 1'b1) begin
            n++;
            if (n > 30) begin
                fails++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
                report_and_stop();
            end
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
    endtask : wait_idle

    // one-cycle event pulse: 0 page hit, 1 descriptor, 2 busy done, 3 tuning
    task automatic pulse(input int sel);
        @(posedge clk);
        case (sel)
            0: dma_page_hit <= 1'b1;
            1: desc_int_hit <= 1'b1;
            2: busy_cmd_done <= 1'b1;
            default: tuning_cmd_done <= 1'b1;
        endcase
        @(posedge clk);
        dma_page_hit <= 1'b0;
        desc_int_hit <= 1'b0;
        busy_cmd_done <= 1'b0;
        tuning_cmd_done <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        {wr, rd, go_read, go_write} = 4'h0;
        addr = 8'h00;
        wdata = 32'h0;
        {busy_cmd_done, tuning_cmd_done, dma_mode, dma_page_hit, desc_int_hit} = 5'h00;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // reset values and an unmapped place
        rd_chk(`EVT_STATUS_OFS, 32'h0);
        rd_chk(`EVT_MASK_OFS, 32'h0);
        rd_chk(`EVT_CTRL_OFS, 32'h0);
        rd_chk(8'h10, 32'h0);
        wr_reg(8'h10, 32'hffffffff);
        rd_chk(`EVT_MASK_OFS, 32'h0);
        check({31'h0, timeout_meaningful}, 32'h1);
        // read transfer without halt: read ready and complete, no gap
        start_xfer(1'b1);
        wait_idle();
        rd_chk(`EVT_STATUS_OFS, 32'h22);
        check({31'h0, wait_seen}, 32'h0);
        check({31'h0, timeout_meaningful}, 32'h0);
        // a zero write leaves flags, a one write clears them
        wr_reg(`EVT_STATUS_OFS, 32'h0);
        rd_chk(`EVT_STATUS_OFS, 32'h22);
        wr_reg(`EVT_STATUS_OFS, 32'h20);
        rd_chk(`EVT_STATUS_OFS, 32'h02);
        wr_reg(`EVT_STATUS_OFS, 32'h02);
        rd_chk(`EVT_STATUS_OFS, 32'h0);
        check({31'h0, timeout_meaningful}, 32'h1);
        // write transfer under a foreign mask, then unmask and clear
        wr_reg(`EVT_MASK_OFS, 32'h20);
        start_xfer(1'b0);
        wait_idle();
        rd_chk(`EVT_STATUS_OFS, 32'h12);
        check({31'h0, irq}, 32'h0);
        wr_reg(`EVT_MASK_OFS, 32'h10);
        #1;
        check({31'h0, irq}, 32'h1);
        wr_reg(`EVT_STATUS_OFS, 32'h12);
        #1;
        check({31'h0, irq}, 32'h0);
        // halted read: read wait offered, gap on line busy fall
        wr_reg(`EVT_CTRL_OFS, 32'h1);
        start_xfer(1'b1);
        repeat (3) @(posedge clk);
        #1;
        check({31'h0, read_wait_req}, 32'h1);
        wait_idle();
        rd_chk(`EVT_STATUS_OFS, 32'h26);
        check({31'h0, wait_seen}, 32'h1);
        wr_reg(`EVT_STATUS_OFS, 32'h3e);
        // halted write: gap on write active fall
        start_xfer(1'b0);
        wait_idle();
        rd_chk(`EVT_STATUS_OFS, 32'h16);
        wr_reg(`EVT_STATUS_OFS, 32'h3e);
        wr_reg(`EVT_CTRL_OFS, 32'h2);
        rd_chk(`EVT_CTRL_OFS, 32'h2);
        // tuning run: each tuning command sets read ready
        pulse(3);
        rd_chk(`EVT_STATUS_OFS, 32'h20);
        wr_reg(`EVT_STATUS_OFS, 32'h20);
        pulse(3);
        rd_chk(`EVT_STATUS_OFS, 32'h20);
        wr_reg(`EVT_STATUS_OFS, 32'h20);
        wr_reg(`EVT_CTRL_OFS, 32'h0);
        pulse(3);
        rd_chk(`EVT_STATUS_OFS, 32'h0);
        // a page hit after completion is dropped in simple dma mode
        pulse(0);
        rd_chk(`EVT_STATUS_OFS, 32'h0);
        // page boundary inside a read transfer
        start_xfer(1'b1);
        pulse(0);
        wait_idle();
        rd_chk(`EVT_STATUS_OFS, 32'h2a);
        wr_reg(`EVT_STATUS_OFS, 32'h3e);
        // descriptor interrupt inside a write transfer
        dma_mode <= 1'b1;
        start_xfer(1'b0);
        pulse(1);
        wait_idle();
        rd_chk(`EVT_STATUS_OFS, 32'h1a);
        wr_reg(`EVT_STATUS_OFS, 32'h3e);
        pulse(1);
        rd_chk(`EVT_STATUS_OFS, 32'h0);
        // command with busy completes
        pulse(2);
        rd_chk(`EVT_STATUS_OFS, 32'h02);
        // a clear and a completion in one cycle: the set wins
        fork
            wr_reg(`EVT_STATUS_OFS, 32'h02);
            pulse(2);
        join
        rd_chk(`EVT_STATUS_OFS, 32'h02);
        // completion latch held, last transfer a write, lines idle
        rd_chk(`EVT_STATE_OFS, 32'h01);
        report_and_stop();
    end
endmodule : tb_host_normal_event_status
